// *** inc/bhm_consts.vh ***
`ifndef BHM_CONSTS_VH
`define BHM_CONSTS_VH
`define BHM_OPND_W      8
`define BHM_PROD_W      16
`define BHM_HI_MSB      15
`define BHM_HI_LSB      8
`define BHM_LO_MSB      7
`define BHM_LO_LSB      0
`define BHM_FLAG_W      8
`define BHM_BYTE_RST    8'h00
`define BHM_SEL_HI      1'b1
`define BHM_SEL_LO      1'b0
`define BHM_ST_IDLE     2'h1
`define BHM_ST_DONE     2'h2
`endif

// *** logic/bhm_multiplier.v ***
// Functional notes
// RULE1 - Both 8-bit operands are unsigned; full 16-bit product, never truncated.
// RULE2 - Multiply completes in one instruction cycle; next instruction sees product.
// RULE3 - Product high byte goes to high register, low byte to low register.
// RULE4 - Multiply never changes any ALU status flag.
// RULE5 - Operands come from working register and the named file register.
// RULE6 - Software builds signed products by subtracting operands from high byte.
// RULE7 - Multiply changes nothing except the product register pair.
`timescale 1ns/1ps
`include "bhm_consts.vh"

module bhm_multiplier (
  input  wire                     i_clk,
  input  wire                     i_rst_n,
  input  wire                     i_mul_go,
  input  wire [`BHM_OPND_W-1:0]   i_working_register,
  input  wire [`BHM_OPND_W-1:0]   i_file_operand,
  input  wire                     i_prod_hi_wr,
  input  wire                     i_prod_lo_wr,
  input  wire [`BHM_OPND_W-1:0]   i_prod_wr_data,
  input  wire [`BHM_FLAG_W-1:0]   i_alu_flag_register,
  output reg  [`BHM_OPND_W-1:0]   o_product_high_byte,
  output reg  [`BHM_OPND_W-1:0]   o_product_low_byte,
  output wire [`BHM_FLAG_W-1:0]   o_alu_flag_register,
  output wire [`BHM_OPND_W-1:0]   o_working_register,
  output wire [`BHM_OPND_W-1:0]   o_file_operand,
  output reg                      o_mul_done
);

  localparam [1:0] ST_IDLE = `BHM_ST_IDLE;
  localparam [1:0] ST_DONE = `BHM_ST_DONE;
  localparam       ACC_W   = `BHM_PROD_W * (`BHM_OPND_W + 1);

  wire [`BHM_PROD_W-1:0] prod_full;
  wire [ACC_W-1:0]       acc_flat;
  wire [`BHM_OPND_W-1:0] high_byte_d;
  wire [`BHM_OPND_W-1:0] low_byte_d;
  reg  [1:0]             state_q;
  reg  [1:0]             state_d;
  reg                    done_d;

  // Each row adds a shifted copy of the working register when its bit of
  // the file operand is set; rows of zeros keep the adder chain uniform.
  function [`BHM_PROD_W-1:0] row_addend;
    input [`BHM_OPND_W-1:0] multiplicand;
    input                   select;
    input integer           shift;
    reg   [`BHM_PROD_W-1:0] wide;
    begin
      wide = {{`BHM_OPND_W{1'b0}}, multiplicand};
      if (select) begin
        row_addend = wide << shift;
      end else begin
        row_addend = {`BHM_PROD_W{1'b0}};
      end
    end
  endfunction

  // Picks one half of a product word for its byte register.
  function [`BHM_OPND_W-1:0] product_half;
    input [`BHM_PROD_W-1:0] word;
    input                   upper;
    begin
      if (upper) begin
        product_half = word[`BHM_HI_MSB:`BHM_HI_LSB];
      end else begin
        product_half = word[`BHM_LO_MSB:`BHM_LO_LSB];
      end
    end
  endfunction

  // A multiply wins over a direct byte write in the same cycle, since the
  // core cannot issue both and the product must not be torn.
  function [`BHM_OPND_W-1:0] byte_next;
    input [`BHM_OPND_W-1:0] current;
    input [`BHM_OPND_W-1:0] from_mul;
    input                   mul_go;
    input                   wr_en;
    input [`BHM_OPND_W-1:0] wr_data;
    begin
      if (mul_go) begin
        byte_next = from_mul;
      end else if (wr_en) begin
        byte_next = wr_data;
      end else begin
        byte_next = current;
      end
    end
  endfunction

  // Full-adder cell, shared by every column of every row.
  function fa_sum;
    input a;
    input b;
    input c;
    begin
      fa_sum = a ^ b ^ c;
    end
  endfunction

  function fa_carry;
    input a;
    input b;
    input c;
    begin
      fa_carry = (a & b) | (a & c) | (b & c);
    end
  endfunction

  // A purely combinational array keeps the whole multiply inside one
  // instruction cycle; the cost is a long ripple path through the rows.
  assign acc_flat[`BHM_PROD_W-1:0] = {`BHM_PROD_W{1'b0}};

  genvar row;
  genvar col;
  generate
    for (row = 0; row < `BHM_OPND_W; row = row + 1) begin : g_row
      wire [`BHM_PROD_W-1:0] addend;
      wire [`BHM_PROD_W-1:0] part;
      wire [`BHM_PROD_W-1:0] sum;
      wire [`BHM_PROD_W:0]   carry;

      assign addend   = row_addend(i_working_register,
                                   i_file_operand[row],
                                   row); // RULE1 RULE5
      assign part     = acc_flat[row*`BHM_PROD_W +: `BHM_PROD_W];
      assign carry[0] = 1'b0;

      for (col = 0; col < `BHM_PROD_W; col = col + 1) begin : g_col
        assign sum[col]     = fa_sum(part[col],
                                     addend[col],
                                     carry[col]);
        assign carry[col+1] = fa_carry(part[col],
                                       addend[col],
                                       carry[col]);
      end

      assign acc_flat[(row+1)*`BHM_PROD_W +: `BHM_PROD_W] = sum;
    end
  endgenerate

  // The top carry of every row stays clear: an unsigned 8 by 8 product
  // always fits in 16 bits, so nothing is lost by dropping it.
  assign prod_full =
    acc_flat[`BHM_OPND_W*`BHM_PROD_W +: `BHM_PROD_W]; // RULE1

  assign high_byte_d = byte_next(o_product_high_byte,
                                 product_half(prod_full, `BHM_SEL_HI),
                                 i_mul_go,
                                 i_prod_hi_wr,
                                 i_prod_wr_data); // RULE3
  assign low_byte_d  = byte_next(o_product_low_byte,
                                 product_half(prod_full, `BHM_SEL_LO),
                                 i_mul_go,
                                 i_prod_lo_wr,
                                 i_prod_wr_data); // RULE3

  // The product is unsigned only. Software corrects the high byte for
  // signed operands through the direct byte writes, so those writes must
  // stay open to the core even though the multiplier never needs them.
  // A write in the same cycle as a multiply is dropped without notice.
  // Flags and operands pass straight through; a multiply never rewrites them.
  assign o_alu_flag_register = i_alu_flag_register; // RULE4
  assign o_working_register  = i_working_register; // RULE7
  assign o_file_operand      = i_file_operand; // RULE7

  // The state only mirrors whether the last cycle held a request; it
  // drives no output, and the done flag never reads it.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (i_mul_go) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!i_mul_go) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Every cycle with a request is one multiply, so done simply follows it.
  always @* begin
    done_d = i_mul_go; // RULE2
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q    <= ST_IDLE;
      o_mul_done <= 1'b0;
    end else begin
      state_q    <= state_d;
      o_mul_done <= done_d; // RULE2
    end
  end

  // Besides the state and done flag, only the product bytes hold state; flags and operands have none.
  // Each byte has its own process so a write to one cannot touch the other.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_product_high_byte <= `BHM_BYTE_RST;
    end else begin
      o_product_high_byte <= high_byte_d; // RULE3
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_product_low_byte <= `BHM_BYTE_RST;
    end else begin
      o_product_low_byte <= low_byte_d; // RULE3
    end
  end

endmodule

// *** tb/bhm_monitor.sv ***
`timescale 1ns/1ps
module bhm_mon(
  input wire logic       i_clk,i_rst_n,i_mul_go,i_prod_hi_wr,i_prod_lo_wr,
  input wire logic       o_mul_done,
  input wire logic [7:0] i_working_register,i_file_operand,o_product_low_byte,
  input wire logic [7:0] i_alu_flag_register,o_alu_flag_register,
  input wire logic [7:0] o_product_high_byte
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire [15:0] r = {o_product_high_byte,o_product_low_byte};
  wire [15:0] p = i_working_register*i_file_operand;
  wire        n = !(i_mul_go|i_prod_hi_wr|i_prod_lo_wr);
  full_prod_a: assert property(i_mul_go|=>r==$past(p))else $error("p");
  one_cycle_a: assert property(i_mul_go|=>o_mul_done)else $error("d");
  high_byte_a: assert property(i_mul_go|=>r[15:8]==$past(p[15:8]))
    else $error("h");
  flag_keep_a: assert property(o_alu_flag_register==i_alu_flag_register)
    else $error("f");
  low_byte_a: assert property(i_mul_go|=>r[7:0]==$past(p[7:0]))
    else $error("l");
  prod_hold_a: assert property(n|=>$stable(r))else $error("s");
  cover property(i_mul_go[*2]);
  cover property(i_prod_hi_wr);
  cover property(i_mul_go##1!i_mul_go);
endmodule
bind bhm_multiplier bhm_mon mon_u(.*);

// *** tb/bhm_core.sv ***
`timescale 1ns/1ps
module bhm_core(
  input  wire logic       i_clk,en,
  output logic            i_mul_go = '0,
  output logic [7:0]      i_working_register = '0,i_file_operand = '0
);
  always @(negedge i_clk) begin
    i_mul_go <= en;
    if (en) {i_working_register,i_file_operand} <= 16'($urandom);
  end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`define CK(a,b) begin tests_run++; if((a)!==(b)) begin error_cnt++; \
  $display("BAD %0t diff",$time); end end
module tb;
  logic i_clk=0,i_rst_n=0,en=0,i_prod_hi_wr=0,i_prod_lo_wr=0,i_mul_go,o_mul_done;
  logic [7:0] i_alu_flag_register='0,i_prod_wr_data='0,i_working_register,
    i_file_operand,o_product_high_byte,o_product_low_byte,o_alu_flag_register,
    o_working_register,o_file_operand;
  logic [15:0] q[$];
  logic signed [15:0] p;
  int error_cnt=0,tests_run=0;
  always #25 i_clk=~i_clk;
  bhm_core pm_u(.*);
  bhm_multiplier dut_u(.*);
  always @(posedge i_clk) if (i_mul_go)
    q.push_back(16'(i_working_register)*i_file_operand);
  always @(negedge i_clk) if (o_mul_done)
    `CK({o_product_high_byte,o_product_low_byte},q.pop_front())
  always @(negedge i_clk) `CK(o_alu_flag_register,i_alu_flag_register)
  always @(negedge i_clk) `CK({o_working_register,o_file_operand},{i_working_register,i_file_operand})
  task end_sim;
    $display("errors %0d checks %0d",error_cnt,tests_run);
    if (error_cnt==0&&tests_run>0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h9b94));
    repeat(12) @(negedge i_clk);
    i_rst_n <= 1;
    repeat(80) @(negedge i_clk) begin
      en <= 1'($urandom);
      i_alu_flag_register <= 8'($urandom);
    end
    @(negedge i_clk) en <= 0;
    repeat(2) @(negedge i_clk);
    p = $signed(i_working_register)*$signed(i_file_operand);
    i_prod_wr_data <= o_product_high_byte-(i_file_operand[7]?i_working_register:'0)
      -(i_working_register[7]?i_file_operand:'0);
    i_prod_hi_wr <= 1;
    @(negedge i_clk) i_prod_hi_wr <= 0;
    @(negedge i_clk) `CK(o_product_high_byte,p[15:8])
    i_prod_wr_data <= 8'($urandom);
    i_prod_lo_wr <= 1;
    @(negedge i_clk) i_prod_lo_wr <= 0;
    @(negedge i_clk) `CK(o_product_low_byte,i_prod_wr_data)
    `CK(q.size(),0)
    end_sim;
  end
endmodule
